// ### include/anu_pkg.sv
// Shared constants, types and helpers of the normalize / OR unit
package anu_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CMD     = 8'h04;
  localparam logic [7:0] ADDR_OPERAND = 8'h08;
  localparam logic [7:0] ADDR_ACC     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_AR_BASE = 8'h20;
  localparam logic [7:0] ADDR_AR_LAST = 8'h3C;

  // Field positions
  localparam int CTRL_SXM_BIT    = 0;
  localparam int CTRL_EXT_BIT    = 1;
  localparam int CMD_OP_LSB      = 0;
  localparam int CMD_SEL_LSB     = 4;
  localparam int CMD_MOD_LSB     = 8;
  localparam int CMD_SHIFT_LSB   = 12;
  localparam int CMD_RPT_LSB     = 16;
  localparam int STAT_TC_BIT     = 0;
  localparam int STAT_ARP_LSB    = 1;
  localparam int STAT_BUSY_BIT   = 4;
  localparam int ACC_SIGN_BIT    = 31;
  localparam int ACC_NEXT_BIT    = 30;

  // Reset values
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [15:0] AR_RESET  = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation codes carried in the command register
  localparam logic [2:0] OP_NOP     = 3'h0;
  localparam logic [2:0] OP_NORMALIZE_INSTR    = 3'h1;
  localparam logic [2:0] OP_OR_DATA = 3'h2;
  localparam logic [2:0] OP_OR_LK   = 3'h3;
  localparam logic [2:0] OP_OR_LK16 = 3'h4;
  localparam logic [2:0] OP_LAR     = 3'h5;
  localparam logic [2:0] OP_MAR     = 3'h6;

  // Auxiliary register modification codes; zero is the increment default
  localparam logic [2:0] MOD_INC    = 3'h0;
  localparam logic [2:0] MOD_NONE   = 3'h1;
  localparam logic [2:0] MOD_DEC    = 3'h2;
  localparam logic [2:0] MOD_ADD0   = 3'h3;
  localparam logic [2:0] MOD_SUB0   = 3'h4;

  // One instruction word as it moves down the pipeline
  typedef struct packed {
    logic        vld;
    logic [2:0]  op;
    logic [2:0]  sel;
    logic [2:0]  mod;
    logic [3:0]  shift;
    logic [15:0] opnd;
  } anu_word_t;

  localparam anu_word_t WORD_IDLE = '0;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_RUN} anu_seq_t;

  function automatic logic [15:0] ar_modify(input logic [15:0] ar, input logic [15:0] ar0,
                                            input logic [2:0] mod);
    logic [15:0] res;
    res = ar;
    if (mod == MOD_INC) begin
      res = ar + 16'h0001;
    end else if (mod == MOD_DEC) begin
      res = ar - 16'h0001;
    end else if (mod == MOD_ADD0) begin
      res = ar + ar0;
    end else if (mod == MOD_SUB0) begin
      res = ar - ar0;
    end
    return res;
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

endpackage

// ### src/anu_normalize_instr_step.sv
// One normalize step on the 32-bit accumulator
module anu_normalize_instr_step (
  input  wire logic [31:0] acc,
  output logic      [31:0] acc_nxt,
  output logic             tc,
  output logic             shifted
);

  logic stop;

  // Zero or differing top bits: already normalized
  assign stop    = (acc == 32'h0000_0000) | (acc[anu_pkg::ACC_SIGN_BIT] ^ acc[anu_pkg::ACC_NEXT_BIT]);
  assign tc      = stop;
  assign shifted = ~stop;
  assign acc_nxt = stop ? acc : {acc[30:0], 1'b0};

endmodule

// ### src/anu_core.sv
// Accumulator normalize and OR execution unit with AXI4-Lite registers
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
module anu_core #(
  parameter int PROG_WAIT = 0
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Bus slave state
  logic                 awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]           bresp_ff, rresp_ff;
  logic [31:0]          rdata_ff;
  logic                 aw_full_ff, w_full_ff;
  logic [7:0]           waddr_ff;
  logic [31:0]          wdata_ff;
  logic [3:0]           wstrb_ff;
  // Block state
  logic                 sxm_ff, ext_ff, tc_ff;
  logic [2:0]           arp_ff;
  logic [31:0]          acc_ff, cmd_ff;
  logic [15:0]          opnd_ff;
  logic [15:0]          ar_ff [8];
  logic [15:0]          nxt_ar [8];
  anu_pkg::anu_seq_t    seq_ff;
  logic [7:0]           rpt_ff;
  logic [15:0]          wait_ff;
  anu_pkg::anu_word_t   dec_ff, rd_ff, ex_ff;

  // Write channel decode
  wire aw_take   = s_axi_awvalid & awready_ff;
  wire w_take    = s_axi_wvalid & wready_ff;
  wire wr_commit = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire ar_take   = s_axi_arvalid & arready_ff;
  wire busy      = (seq_ff != anu_pkg::SEQ_IDLE) | dec_ff.vld | rd_ff.vld | ex_ff.vld;

  wire wr_ctrl   = wr_commit & (waddr_ff == anu_pkg::ADDR_CTRL);
  wire wr_cmd    = wr_commit & (waddr_ff == anu_pkg::ADDR_CMD);
  wire wr_opnd   = wr_commit & (waddr_ff == anu_pkg::ADDR_OPERAND);
  wire wr_acc    = wr_commit & (waddr_ff == anu_pkg::ADDR_ACC);
  wire wr_stat   = wr_commit & (waddr_ff == anu_pkg::ADDR_STATUS);
  wire wr_ar     = wr_commit & (waddr_ff >= anu_pkg::ADDR_AR_BASE) & (waddr_ff <= anu_pkg::ADDR_AR_LAST)
                   & (waddr_ff[1:0] == 2'h0);
  wire [2:0] wr_ar_idx = waddr_ff[4:2];
  wire wr_ok     = wr_ctrl | wr_cmd | wr_opnd | wr_acc | wr_stat | wr_ar;

  wire [31:0] wr_val   = anu_pkg::apply_strb(32'h0000_0000, wdata_ff, wstrb_ff);
  wire [31:0] cmd_new  = anu_pkg::apply_strb(cmd_ff, wdata_ff, wstrb_ff);
  wire [31:0] acc_new  = anu_pkg::apply_strb(acc_ff, wdata_ff, wstrb_ff);
  wire [31:0] ctrl_cur = {30'h0, ext_ff, sxm_ff};
  wire [31:0] ctrl_new = anu_pkg::apply_strb(ctrl_cur, wdata_ff, wstrb_ff);
  wire [31:0] opnd_new = anu_pkg::apply_strb({16'h0000, opnd_ff}, wdata_ff, wstrb_ff);
  wire [31:0] stat_cur = {27'h0, busy, arp_ff, tc_ff};

  // Read decode
  wire [2:0]  rd_ar_idx = s_axi_araddr[4:2];
  wire        rd_ar     = (s_axi_araddr >= anu_pkg::ADDR_AR_BASE) & (s_axi_araddr <= anu_pkg::ADDR_AR_LAST)
                          & (s_axi_araddr[1:0] == 2'h0);
  wire        rd_ok     = rd_ar | (s_axi_araddr == anu_pkg::ADDR_CTRL) | (s_axi_araddr == anu_pkg::ADDR_CMD)
                          | (s_axi_araddr == anu_pkg::ADDR_OPERAND) | (s_axi_araddr == anu_pkg::ADDR_ACC)
                          | (s_axi_araddr == anu_pkg::ADDR_STATUS);
  wire [31:0] rd_val    = (s_axi_araddr == anu_pkg::ADDR_CTRL)    ? ctrl_cur :
                          (s_axi_araddr == anu_pkg::ADDR_CMD)     ? cmd_ff :
                          (s_axi_araddr == anu_pkg::ADDR_OPERAND) ? {16'h0000, opnd_ff} :
                          (s_axi_araddr == anu_pkg::ADDR_ACC)     ? acc_ff :
                          (s_axi_araddr == anu_pkg::ADDR_STATUS)  ? stat_cur :
                          rd_ar                                   ? {16'h0000, ar_ff[rd_ar_idx]} :
                          32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= anu_pkg::RESP_OKAY;
      waddr_ff   <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      aw_full_ff <= (aw_full_ff | aw_take) & ~wr_commit;
      w_full_ff  <= (w_full_ff | w_take) & ~wr_commit;
      bvalid_ff  <= wr_commit | (bvalid_ff & ~s_axi_bready);
      awready_ff <= ~(aw_full_ff | aw_take) | wr_commit;
      wready_ff  <= ~(w_full_ff | w_take) | wr_commit;
      if (aw_take) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_commit) begin
        bresp_ff <= wr_ok ? anu_pkg::RESP_OKAY : anu_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= anu_pkg::RESP_OKAY;
    end else begin
      rvalid_ff  <= ar_take | (rvalid_ff & ~s_axi_rready);
      arready_ff <= ~(ar_take | (rvalid_ff & ~s_axi_rready));
      if (ar_take) begin
        rdata_ff <= rd_val;
        rresp_ff <= rd_ok ? anu_pkg::RESP_OKAY : anu_pkg::RESP_SLVERR;
      end
    end
  end

  // Issue sequencer: one word per cycle, count+1 words in all
  wire                start   = wr_cmd & ~busy;
  wire                issue   = (seq_ff == anu_pkg::SEQ_RUN);
  anu_pkg::anu_word_t cmd_word;
  assign cmd_word = '{vld:   1'b1,
                      op:    cmd_ff[anu_pkg::CMD_OP_LSB +: 3],
                      sel:   cmd_ff[anu_pkg::CMD_SEL_LSB +: 3],
                      mod:   cmd_ff[anu_pkg::CMD_MOD_LSB +: 3],
                      shift: cmd_ff[anu_pkg::CMD_SHIFT_LSB +: 4],
                      opnd:  opnd_ff};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_ff  <= anu_pkg::SEQ_IDLE;
      rpt_ff  <= 8'h00;
      wait_ff <= 16'h0000;
    end else begin
      case (seq_ff)
        anu_pkg::SEQ_IDLE: begin
          if (start) begin
            rpt_ff  <= cmd_new[anu_pkg::CMD_RPT_LSB +: 8];
            wait_ff <= 16'(PROG_WAIT);
            seq_ff  <= (ext_ff && PROG_WAIT > 0) ? anu_pkg::SEQ_WAIT : anu_pkg::SEQ_RUN;
          end
        end
        anu_pkg::SEQ_WAIT: begin
          wait_ff <= wait_ff - 16'h0001;
          if (wait_ff == 16'h0001) begin
            seq_ff <= anu_pkg::SEQ_RUN;
          end
        end
        anu_pkg::SEQ_RUN: begin
          rpt_ff <= rpt_ff - 8'h01;
          if (rpt_ff == 8'h00) begin
            seq_ff <= anu_pkg::SEQ_IDLE;
          end
        end
        default: begin
          seq_ff <= anu_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Decode, operand read, execute
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_ff <= anu_pkg::WORD_IDLE;
      rd_ff  <= anu_pkg::WORD_IDLE;
      ex_ff  <= anu_pkg::WORD_IDLE;
    end else begin
      dec_ff <= issue ? cmd_word : anu_pkg::WORD_IDLE;
      rd_ff  <= dec_ff;
      ex_ff  <= rd_ff;
    end
  end

  logic [31:0] normalize_instr_acc;
  logic        normalize_instr_tc;
  logic        normalize_instr_shifted;

  anu_normalize_instr_step u_normalize_instr (
    .acc     (acc_ff),
    .acc_nxt (normalize_instr_acc),
    .tc      (normalize_instr_tc),
    .shifted (normalize_instr_shifted)
  );

  wire ex_normalize_instr  = ex_ff.vld & (ex_ff.op == anu_pkg::OP_NORMALIZE_INSTR);
  wire dec_lar  = dec_ff.vld & (dec_ff.op == anu_pkg::OP_LAR);
  wire dec_mar  = dec_ff.vld & (dec_ff.op == anu_pkg::OP_MAR);
  wire normalize_instr_mod = ex_normalize_instr & normalize_instr_shifted;

  // Zero-filled operands; sign extension mode plays no part
  wire [31:0] or_data = {16'h0000, ex_ff.opnd};
  wire [31:0] or_lk   = {16'h0000, ex_ff.opnd} << ex_ff.shift;
  wire [31:0] or_lk16 = {ex_ff.opnd, 16'h0000};

  wire [31:0] nxt_acc = !ex_ff.vld                          ? (wr_acc && !busy ? acc_new : acc_ff) :
                        (ex_ff.op == anu_pkg::OP_NORMALIZE_INSTR)      ? normalize_instr_acc :
                        (ex_ff.op == anu_pkg::OP_OR_DATA)   ? (acc_ff | or_data) :
                        (ex_ff.op == anu_pkg::OP_OR_LK)     ? (acc_ff | or_lk) :
                        (ex_ff.op == anu_pkg::OP_OR_LK16)   ? (acc_ff | or_lk16) :
                        acc_ff;

  // Decode-stage changes first, then the normalize update on top
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      nxt_ar[i] = ar_ff[i];
      if (wr_ar && !busy && wr_ar_idx == 3'(i)) begin
        nxt_ar[i] = wr_val[15:0];
      end
      if (dec_lar && dec_ff.sel == 3'(i)) begin
        nxt_ar[i] = dec_ff.opnd;
      end
      if (dec_mar && arp_ff == 3'(i)) begin
        nxt_ar[i] = anu_pkg::ar_modify(ar_ff[i], ar_ff[0], dec_ff.mod);
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (normalize_instr_mod && arp_ff == 3'(i)) begin
        nxt_ar[i] = anu_pkg::ar_modify(nxt_ar[i], ar_ff[0], ex_ff.mod);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        ar_ff[i] <= anu_pkg::AR_RESET;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        ar_ff[i] <= nxt_ar[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff  <= anu_pkg::ACC_RESET;
      tc_ff   <= 1'b0;
      arp_ff  <= 3'h0;
      sxm_ff  <= 1'b0;
      ext_ff  <= 1'b0;
      cmd_ff  <= 32'h0000_0000;
      opnd_ff <= 16'h0000;
    end else begin
      acc_ff <= nxt_acc;
      if (ex_normalize_instr) begin
        tc_ff <= normalize_instr_tc;
      end
      if (dec_mar) begin
        arp_ff <= dec_ff.sel;
      end
      if (wr_ctrl) begin
        sxm_ff <= ctrl_new[anu_pkg::CTRL_SXM_BIT];
        ext_ff <= ctrl_new[anu_pkg::CTRL_EXT_BIT];
      end
      if (wr_cmd && !busy) begin
        cmd_ff <= cmd_new;
      end
      if (wr_opnd && !busy) begin
        opnd_ff <= opnd_new[15:0];
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

endmodule

// ### tb/anu_core_props.sv
// Bus handshake checks on the normalize / OR unit ports
module anu_core_props #(
  parameter int PROG_WAIT = 0
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire aw_w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_take   = s_axi_arvalid && s_axi_arready;

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while read pending");
  write_answer_a: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered in time");
  write_unmapped_a: assert property (aw_w_take && s_axi_awaddr == 8'h40 |-> ##[1:2] s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  read_unmapped_a: assert property (ar_take && s_axi_araddr == 8'h14 |=> s_axi_rresp == 2'h2 && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  read_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(ar_take))
    else $error("read answer without request");
endmodule

bind anu_core anu_core_props #(.PROG_WAIT(PROG_WAIT)) u_props (
  .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// ### tb/tb_anu_core.sv
// Self-checking bench for the normalize / OR unit
module tb_anu_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          num_errors = 0;
  int          check_count = 0;
  int          seed = 5581;
  int unsigned m_acc = 0, m_arp = 0, m_tc = 0, m_ar[8] = '{default: 0};

  always #20 clk = ~clk;

  anu_core #(.PROG_WAIT(2)) i_dut (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = anu_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r = anu_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(r));
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = anu_pkg::RESP_OKAY);
    logic [31:0] d;
    rd(a, d, r);
    chk(d, e);
  endtask

  function automatic int unsigned armod(int unsigned v, int md);
    case (md)
      0: return (v + 1) & 32'h0000_ffff;
      2: return (v - 1) & 32'h0000_ffff;
      3: return (v + m_ar[0]) & 32'h0000_ffff;
      4: return (v - m_ar[0]) & 32'h0000_ffff;
      default: return v;
    endcase
  endfunction

  task automatic ld(input int unsigned acc, input int unsigned opnd);
    wr(8'h0C, acc);
    wr(8'h08, opnd);
    m_acc = acc;
  endtask

  // Issue one command, wait for idle, then step the model and compare
  task automatic run(input int op, input int sel, input int md, input int sh, input int rp, input int unsigned v);
    logic [31:0] d;
    int n;
    wr(8'h04, 32'(rp << 16 | sh << 12 | md << 8 | sel << 4 | op));
    n = 0;
    do begin
      rd(8'h10, d);
      n++;
    end while (d[4] !== 1'b0 && n < 200);
    chk(32'(d[4]), 32'h0000_0000);
    for (int i = 0; i <= rp; i++) begin
      if (op == 1 && (m_acc == 0 || m_acc[31] != m_acc[30])) m_tc = 1;
      else if (op == 1) begin
        m_tc = 0;
        m_acc = m_acc << 1;
        m_ar[m_arp] = armod(m_ar[m_arp], md);
      end
    end
    case (op)
      2: m_acc |= v;
      3: m_acc |= v << sh;
      4: m_acc |= v << 16;
      5: m_ar[sel] = v;
      6: begin
        m_ar[m_arp] = armod(m_ar[m_arp], md);
        m_arp = sel;
      end
      default: ;
    endcase
    rc(8'h0C, m_acc);
    rc(8'h10, m_arp << 1 | m_tc);
    rc(8'h20 + 8'(m_arp * 4), m_ar[m_arp]);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    num_errors++;
    test_done;
  end

  initial begin
    int unsigned v;
    int unsigned nv[6] = '{32'h0FFF_F001, 0, 32'h4000_0000, 32'hBFFF_FFFF, 32'hFFFF_F001, 32'h8000_0000};
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 13; i++) rc(i < 5 ? 8'(i * 4) : 8'(i * 4 + 12), 0);
    rc(8'h14, 0, anu_pkg::RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF, anu_pkg::RESP_SLVERR);
    rc(8'h40, 0, anu_pkg::RESP_SLVERR);
    $display("test reset_map done");
    v = $random(seed) & 32'h0000_ffff;
    ld(0, v);
    run(5, 3, 1, 0, 0, v);
    run(6, 3, 1, 0, 0, 0);
    foreach (nv[i]) begin
      ld(nv[i], 0);
      run(1, 0, i % 5, 0, 0, 0);
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 32'((k & 1) << 1));
      ld($random(seed) >>> (k * 5), 0);
      run(1, 0, k == 0 ? 2 : 0, 0, k % 2 == 0 ? 14 : k, 0);
    end
    $display("test normalize done");
    wr(8'h00, 32'h0000_0001);
    for (int k = 0; k < 48; k++) begin
      v = $random(seed) & 32'h0000_ffff | 32'h0000_8000;
      ld($random(seed), v);
      run(2 + k % 3, 0, 0, k % 3 == 1 ? k / 3 : 0, 0, v);
    end
    $display("test or_forms done");
    test_done;
  end
endmodule
